// ===== rtl/cmf_pkg.sv
// Constants shared by the mailbox status flag block.
// Assumes a 32-bit AHB-Lite register window and 32 mailboxes.
package cmf_pkg;

    // Mailbox count and index width
    localparam int unsigned NUM_MBX = 32;
    localparam int unsigned MBX_W   = 5;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFF_TX_REQUEST_SET     = 8'h00;
    localparam logic [7:0] OFF_TX_REQUEST_CANCEL  = 8'h04;
    localparam logic [7:0] OFF_TX_SUCCESS_ACK     = 8'h08;
    localparam logic [7:0] OFF_TX_ABORT_ACK       = 8'h0C;
    localparam logic [7:0] OFF_RX_MESSAGE_PENDING = 8'h10;
    localparam logic [7:0] OFF_RX_MESSAGE_LOST    = 8'h14;
    localparam logic [7:0] OFF_MAILBOX_IRQ_MASK   = 8'h18;
    localparam logic [7:0] OFF_MAILBOX_IRQ_LEVEL  = 8'h1C;
    localparam logic [7:0] OFF_OVERWRITE_PROTECT  = 8'h20;
    localparam logic [7:0] OFF_GLOBAL_IRQ_MASK    = 8'h24;
    localparam logic [7:0] OFF_GLOBAL_IRQ_FLAG    = 8'h28;

    // Bit positions in the global flag and mask words
    localparam int unsigned BIT_MBX_FLAG  = 15;
    localparam int unsigned BIT_ABORT     = 14;
    localparam int unsigned BIT_LOST      = 11;

    // Reset values
    localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
    localparam logic [31:0] RST_CTRL  = 32'h0000_0000;

    // AHB encodings
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    // Transmit sequencer states
    typedef enum logic {
        CMF_TX_IDLE,
        CMF_TX_BUSY
    } cmf_tx_state_t;

endpackage : cmf_pkg

// ===== rtl/cmf_mailbox_flags.sv
// Mailbox status and request flags of a 32-mailbox CAN controller,
// with an AHB-Lite register slave and a port to the protocol engine.
// Assumes the engine runs on hclk and pulses done/abort for the
// mailbox handed to it, and offers a vector of identifier matches.
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/10ps

// Behaviour
// - Writing one to request bit n queues mailbox n; zeros ignored.
// - Cancel bits are set by software only, cleared by hardware only.
// - Hardware clears cancel bit when its transmission succeeds or aborts.
// - Software set of a cancel bit wins over a same-cycle hardware clear.
// - Cancel withdraws a queued request of a mailbox not being sent.
// - Cancel on the active mailbox waits for success or abort, then clears.
// - An aborted transmission of mailbox n sets abort flag n.
// - Cancel outcome shows in the abort or success flag of that mailbox.
// - Success sets success flag n; masked mailbox raises global mailbox flag.
// - Writing one clears a success flag and its interrupt; zero ignored.
// - Hardware set of a success flag beats a same-cycle software clear.
// - Any set abort flag sets the global abort flag.
// - Abort flags clear on write one; a colliding set wins.
// - Pending flag set on reception, cleared by software; set wins.
// - Unprotected full mailbox is overwritten; protected one passes to next.
// - Overwriting an unread message sets lost flag n.
// - Write one to pending bit clears pending and lost; lost is read-only.
// - Set pending flag with mask set raises the global mailbox flag.
// - Lost flags never set for a mailbox with overwrite protection.
// - Any lost flag sets the lost flag; mask enables the interrupt.
// - All request, acknowledge, pending and lost flags reset to zero.
// - Highest-numbered pending mailbox is sent first.
module cmf_mailbox_flags (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic      [1:0]  hresp,
    output logic             tx_start,
    output logic      [4:0]  tx_mbx,
    input  wire logic        tx_done,
    input  wire logic        tx_abort,
    input  wire logic        rx_valid,
    input  wire logic [31:0] rx_match,
    output logic             rx_store,
    output logic      [4:0]  rx_store_mbx,
    output logic             rx_dropped,
    output logic             irq_line0,
    output logic             irq_line1
);

    // Highest set bit of a vector, with a found flag on top
    function automatic logic [5:0] pick_high(input logic [31:0] vec);
        logic [5:0] res;
        res = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if (vec[i]) begin
                res = {1'b1, 5'(i)};
            end
        end
        return res;
    endfunction : pick_high

    // One-hot vector for a mailbox index
    function automatic logic [31:0] one_hot(input logic [4:0] idx);
        return 32'h0000_0001 << idx;
    endfunction : one_hot

    // Flag and control registers
    logic [31:0] req_reg, req_next;
    logic [31:0] cancel_reg, cancel_next;
    logic [31:0] succ_reg, succ_next;
    logic [31:0] abort_reg, abort_next;
    logic [31:0] pend_reg, pend_next;
    logic [31:0] lost_reg, lost_next;
    logic [31:0] mim_reg;
    logic [31:0] mil_reg;
    logic [31:0] prot_reg;
    logic [31:0] gim_reg;
    logic        mbx0_flag_reg, mbx1_flag_reg, abort_flag_reg, lost_flag_reg;
    logic        mbx0_flag_next, mbx1_flag_next, abort_flag_next, lost_flag_next;

    // Bus and sequencer registers
    logic                   wr_pend_reg;
    logic [7:0]             wr_addr_reg;
    logic [31:0]            hrdata_reg;
    logic                   hreadyout_reg;
    logic [1:0]             hresp_reg;
    cmf_pkg::cmf_tx_state_t tx_state_reg;
    logic [4:0]             tx_mbx_reg;
    logic                   tx_start_reg;
    logic                   rx_store_reg;
    logic [4:0]             rx_mbx_reg;
    logic                   rx_drop_reg;
    logic                   irq0_reg, irq1_reg;

    // Address phase decode
    wire        addr_take = hsel & htrans[1] & hready;
    wire [7:0]  rd_addr   = haddr[7:0];

    // Data phase write strobes per register
    wire wr_req     = wr_pend_reg & (wr_addr_reg == cmf_pkg::OFF_TX_REQUEST_SET);
    wire wr_cancel  = wr_pend_reg & (wr_addr_reg == cmf_pkg::OFF_TX_REQUEST_CANCEL);
    wire wr_succ    = wr_pend_reg & (wr_addr_reg == cmf_pkg::OFF_TX_SUCCESS_ACK);
    wire wr_abort   = wr_pend_reg & (wr_addr_reg == cmf_pkg::OFF_TX_ABORT_ACK);
    wire wr_pending = wr_pend_reg & (wr_addr_reg == cmf_pkg::OFF_RX_MESSAGE_PENDING);
    wire wr_mim     = wr_pend_reg & (wr_addr_reg == cmf_pkg::OFF_MAILBOX_IRQ_MASK);
    wire wr_mil     = wr_pend_reg & (wr_addr_reg == cmf_pkg::OFF_MAILBOX_IRQ_LEVEL);
    wire wr_prot    = wr_pend_reg & (wr_addr_reg == cmf_pkg::OFF_OVERWRITE_PROTECT);
    wire wr_gim     = wr_pend_reg & (wr_addr_reg == cmf_pkg::OFF_GLOBAL_IRQ_MASK);

    // Write-one masks; zeros in the data leave bits alone
    wire [31:0] set_req    = wr_req     ? hwdata : 32'h0000_0000;
    wire [31:0] set_cancel = wr_cancel  ? hwdata : 32'h0000_0000;
    wire [31:0] clr_succ   = wr_succ    ? hwdata : 32'h0000_0000;
    wire [31:0] clr_abort  = wr_abort   ? hwdata : 32'h0000_0000;
    wire [31:0] clr_pend   = wr_pending ? hwdata : 32'h0000_0000;

    // Engine outcome for the mailbox in flight
    wire        tx_busy    = (tx_state_reg == cmf_pkg::CMF_TX_BUSY);
    wire [31:0] active_vec = tx_busy ? one_hot(tx_mbx_reg) : 32'h0000_0000;
    wire [31:0] done_vec   = (tx_busy & tx_done) ? active_vec : 32'h0000_0000;
    wire [31:0] fail_vec   = (tx_busy & tx_abort & ~tx_done) ? active_vec : 32'h0000_0000;

    // Cancel of a mailbox not in flight takes effect at once
    wire [31:0] withdraw_vec = cancel_reg & req_reg & ~active_vec;
    wire [31:0] cancel_clr   = done_vec | fail_vec | (cancel_reg & ~active_vec);
    wire [31:0] req_clr      = done_vec | fail_vec | withdraw_vec;
    wire [31:0] abort_set    = fail_vec | withdraw_vec;

    // Next-value equations: every hardware set beats a software clear
    assign req_next    = (req_reg & ~req_clr) | set_req;
    assign cancel_next = (cancel_reg & ~cancel_clr) | set_cancel;
    assign succ_next   = (succ_reg & ~clr_succ) | done_vec;
    assign abort_next  = (abort_reg & ~clr_abort) | abort_set;

    // Receive placement: scan matches from the top, skipping protected full ones
    wire [31:0] rx_eligible = rx_match & ~(pend_reg & prot_reg);
    wire [5:0]  rx_pick     = pick_high(rx_eligible);
    wire        rx_hit      = rx_valid & rx_pick[5];
    wire [31:0] rx_set_vec  = rx_hit ? one_hot(rx_pick[4:0]) : 32'h0000_0000;
    wire [31:0] rx_lost_vec = rx_set_vec & pend_reg & ~prot_reg;

    assign pend_next = (pend_reg & ~clr_pend) | rx_set_vec;
    assign lost_next = (lost_reg & ~clr_pend) | rx_lost_vec;

    // Global flags follow the next flag values so they track the same edge
    wire [31:0] mbx_src = (succ_next | pend_next) & mim_reg;
    assign mbx0_flag_next  = |(mbx_src & ~mil_reg);
    assign mbx1_flag_next  = |(mbx_src & mil_reg);
    assign abort_flag_next = |abort_next;
    assign lost_flag_next  = |lost_next;

    // Interrupt lines: mailbox flag per line, abort and lost on line 0
    wire irq0_next = mbx0_flag_next
                   | (abort_flag_next & gim_reg[cmf_pkg::BIT_ABORT])
                   | (lost_flag_next & gim_reg[cmf_pkg::BIT_LOST]);
    wire irq1_next = mbx1_flag_next;

    // Transmit choice: highest-numbered queued mailbox without a cancel
    wire [31:0] tx_eligible = req_reg & ~cancel_reg;
    wire [5:0]  tx_pick     = pick_high(tx_eligible);
    wire        tx_launch   = ~tx_busy & tx_pick[5];

    // Global flag word as read by software
    wire [31:0] gif_word = (32'(mbx0_flag_reg | mbx1_flag_reg) << cmf_pkg::BIT_MBX_FLAG)
                         | (32'(abort_flag_reg) << cmf_pkg::BIT_ABORT)
                         | (32'(lost_flag_reg) << cmf_pkg::BIT_LOST);

    // Read mux, unmapped offsets read zero; bit n is mailbox n except in the global mask and flag words
    logic [31:0] rd_word;
    always_comb begin
        unique case (rd_addr)
            cmf_pkg::OFF_TX_REQUEST_SET:     rd_word = req_reg;
            cmf_pkg::OFF_TX_REQUEST_CANCEL:  rd_word = cancel_reg;
            cmf_pkg::OFF_TX_SUCCESS_ACK:     rd_word = succ_reg;
            cmf_pkg::OFF_TX_ABORT_ACK:       rd_word = abort_reg;
            cmf_pkg::OFF_RX_MESSAGE_PENDING: rd_word = pend_reg;
            cmf_pkg::OFF_RX_MESSAGE_LOST:    rd_word = lost_reg;
            cmf_pkg::OFF_MAILBOX_IRQ_MASK:   rd_word = mim_reg;
            cmf_pkg::OFF_MAILBOX_IRQ_LEVEL:  rd_word = mil_reg;
            cmf_pkg::OFF_OVERWRITE_PROTECT:  rd_word = prot_reg;
            cmf_pkg::OFF_GLOBAL_IRQ_MASK:    rd_word = gim_reg;
            cmf_pkg::OFF_GLOBAL_IRQ_FLAG:    rd_word = gif_word;
            default:                         rd_word = 32'h0000_0000;
        endcase
    end

    // Bus slave: zero wait, read data captured in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg   <= 1'b0;
            wr_addr_reg   <= 8'h00;
            hrdata_reg    <= 32'h0000_0000;
            hreadyout_reg <= 1'b0;
            hresp_reg     <= cmf_pkg::HRESP_OKAY;
        end else begin
            wr_pend_reg   <= addr_take & hwrite;
            wr_addr_reg   <= haddr[7:0];
            hrdata_reg    <= (addr_take & ~hwrite) ? rd_word : 32'h0000_0000;
            hreadyout_reg <= 1'b1;
            hresp_reg     <= cmf_pkg::HRESP_OKAY;
        end
    end

    // Flag registers, all clear after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_reg    <= cmf_pkg::RST_FLAGS;
            cancel_reg <= cmf_pkg::RST_FLAGS;
            succ_reg   <= cmf_pkg::RST_FLAGS;
            abort_reg  <= cmf_pkg::RST_FLAGS;
            pend_reg   <= cmf_pkg::RST_FLAGS;
            lost_reg   <= cmf_pkg::RST_FLAGS;
        end else begin
            req_reg    <= req_next;
            cancel_reg <= cancel_next;
            succ_reg   <= succ_next;
            abort_reg  <= abort_next;
            pend_reg   <= pend_next;
            lost_reg   <= lost_next;
        end
    end

    // Software control words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mim_reg <= cmf_pkg::RST_CTRL;
            mil_reg <= cmf_pkg::RST_CTRL;
            prot_reg <= cmf_pkg::RST_CTRL;
            gim_reg <= cmf_pkg::RST_CTRL;
        end else begin
            mim_reg <= wr_mim ? hwdata : mim_reg;
            mil_reg <= wr_mil ? hwdata : mil_reg;
            prot_reg <= wr_prot ? hwdata : prot_reg;
            gim_reg <= wr_gim ? hwdata : gim_reg;
        end
    end

    // Global flags and interrupt lines
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mbx0_flag_reg  <= 1'b0;
            mbx1_flag_reg  <= 1'b0;
            abort_flag_reg <= 1'b0;
            lost_flag_reg  <= 1'b0;
            irq0_reg  <= 1'b0;
            irq1_reg  <= 1'b0;
        end else begin
            mbx0_flag_reg  <= mbx0_flag_next;
            mbx1_flag_reg  <= mbx1_flag_next;
            abort_flag_reg <= abort_flag_next;
            lost_flag_reg  <= lost_flag_next;
            irq0_reg  <= irq0_next;
            irq1_reg  <= irq1_next;
        end
    end

    // Transmit sequencer: one mailbox in flight at a time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state_reg <= cmf_pkg::CMF_TX_IDLE;
            tx_mbx_reg   <= 5'h00;
            tx_start_reg <= 1'b0;
        end else begin
            tx_start_reg <= tx_launch;
            unique case (tx_state_reg)
                cmf_pkg::CMF_TX_IDLE: begin
                    if (tx_launch) begin
                        tx_state_reg <= cmf_pkg::CMF_TX_BUSY;
                        tx_mbx_reg   <= tx_pick[4:0];
                    end
                end
                cmf_pkg::CMF_TX_BUSY: begin
                    if (tx_done | tx_abort) begin
                        tx_state_reg <= cmf_pkg::CMF_TX_IDLE;
                    end
                end
            endcase
        end
    end

    // Receive placement report to the engine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_store_reg <= 1'b0;
            rx_mbx_reg   <= 5'h00;
            rx_drop_reg  <= 1'b0;
        end else begin
            rx_store_reg <= rx_hit;
            rx_mbx_reg   <= rx_hit ? rx_pick[4:0] : rx_mbx_reg;
            rx_drop_reg  <= rx_valid & ~rx_pick[5];
        end
    end

    // Outputs straight from flops
    assign hrdata       = hrdata_reg;
    assign hreadyout    = hreadyout_reg;
    assign hresp        = hresp_reg;
    assign tx_start     = tx_start_reg;
    assign tx_mbx       = tx_mbx_reg;
    assign rx_store     = rx_store_reg;
    assign rx_store_mbx = rx_mbx_reg;
    assign rx_dropped   = rx_drop_reg;
    assign irq_line0    = irq0_reg;
    assign irq_line1    = irq1_reg;

    // Checks on the flag logic
    a_request_set_one: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_req |=> ((req_reg & $past(hwdata)) == $past(hwdata)))
        else $error("request bits written one not set");

    a_cancel_sw_only: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ((cancel_reg & ~$past(cancel_reg)) & ~$past(set_cancel)) == 32'h0000_0000)
        else $error("cancel bit set without a software write");

    a_cancel_set_wins: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (set_cancel != 32'h0000_0000)
        |=> ((cancel_reg & $past(set_cancel)) == $past(set_cancel)))
        else $error("software cancel set lost");

    a_withdraw_aborts: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (withdraw_vec != 32'h0000_0000) && (set_req == 32'h0000_0000)
        |=> ((req_reg & $past(withdraw_vec)) == 32'h0000_0000)
            && ((abort_reg & $past(withdraw_vec)) == $past(withdraw_vec)))
        else $error("cancel did not withdraw request");

    a_active_kept: assert property (
        @(posedge hclk) disable iff (!hresetn)
        tx_busy && !tx_done && !tx_abort && req_reg[tx_mbx_reg]
        |=> req_reg[$past(tx_mbx_reg)])
        else $error("active mailbox request dropped early");

    a_done_success: assert property (
        @(posedge hclk) disable iff (!hresetn)
        tx_busy && tx_done && !set_cancel[tx_mbx_reg]
        |=> succ_reg[$past(tx_mbx_reg)] && !cancel_reg[$past(tx_mbx_reg)]
                               && (tx_state_reg == cmf_pkg::CMF_TX_IDLE))
        else $error("success not recorded");

    a_abort_global: assert property (
        @(posedge hclk) disable iff (!hresetn)
        tx_busy && tx_abort && !tx_done |=> abort_reg[$past(tx_mbx_reg)] ##0 abort_flag_reg)
        else $error("abort not flagged");

    a_success_w1c: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_succ |=> ((succ_reg & $past(hwdata) & ~$past(done_vec)) == 32'h0000_0000)
                  && ((succ_reg & $past(done_vec)) == $past(done_vec)))
        else $error("success clear misbehaved");

    a_pend_clear_lost: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pending && (rx_set_vec == 32'h0000_0000)
        |=> (((pend_reg | lost_reg) & $past(hwdata)) == 32'h0000_0000))
        else $error("pending clear left bits");

    a_overwrite_lost: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rx_hit && pend_reg[rx_pick[4:0]] |=> lost_reg[$past(rx_pick[4:0])]
            && ((lost_reg & ~$past(lost_reg) & $past(prot_reg)) == 32'h0000_0000))
        else $error("overwrite not marked lost");

    a_lost_irq: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (lost_reg != 32'h0000_0000) |-> lost_flag_reg
        && (!$past(gim_reg[cmf_pkg::BIT_LOST]) || irq_line0))
        else $error("lost interrupt missing");

    a_tx_priority: assert property (
        @(posedge hclk) disable iff (!hresetn)
        tx_launch |=> tx_start_reg && (($past(tx_eligible) >> tx_mbx_reg) == 32'h0000_0001)
        ##1 !tx_start_reg)
        else $error("wrong mailbox chosen");

endmodule : cmf_mailbox_flags

// ===== tb/cmf_engine_model.sv
// Behavioural protocol engine facing the mailbox flag block.
// Assumes the same hclk; answers each start after lag+1 cycles.
`timescale 1ns/10ps
module cmf_engine_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       tx_start,
    input  wire logic       fail_next,
    input  wire logic [3:0] lag,
    output logic            tx_done,
    output logic            tx_abort
);
    logic [4:0] cnt;

    // Count down from a start, then pulse done or abort once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt      <= 5'h00;
            tx_done  <= 1'b0;
            tx_abort <= 1'b0;
        end else begin
            tx_done  <= 1'b0;
            tx_abort <= 1'b0;
            if (tx_start) begin
                cnt <= {1'b0, lag} + 5'h01;
            end else if (cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
                if (cnt == 5'h01) begin
                    tx_done  <= !fail_next;
                    tx_abort <= fail_next;
                end
            end
        end
    end
endmodule : cmf_engine_model

// ===== tb/cmf_mailbox_flags_tb_top.sv
// Self-checking bench for the mailbox flag block over AHB-Lite.
// Assumes zero-wait slave; engine model answers transmit starts.
`timescale 1ns/10ps
module cmf_mailbox_flags_tb_top;
    logic        hclk, hresetn, hsel, hwrite, rx_valid, fail_next;
    logic [31:0] haddr, hwdata, hrdata, rx_match, rd;
    logic [1:0]  htrans, hresp;
    logic [2:0]  hsize;
    logic [3:0]  lag;
    logic [4:0]  tx_mbx, rx_store_mbx, seen_mbx, prev_mbx;
    logic        hreadyout, tx_start, tx_done, tx_abort, rx_store, rx_dropped;
    logic        irq_line0, irq_line1;
    int          fail_count, checked, drops, stores;

    cmf_mailbox_flags DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .tx_start(tx_start), .tx_mbx(tx_mbx), .tx_done(tx_done), .tx_abort(tx_abort),
        .rx_valid(rx_valid), .rx_match(rx_match), .rx_store(rx_store),
        .rx_store_mbx(rx_store_mbx), .rx_dropped(rx_dropped),
        .irq_line0(irq_line0), .irq_line1(irq_line1));
    cmf_engine_model ENG (.hclk(hclk), .hresetn(hresetn), .tx_start(tx_start),
        .fail_next(fail_next), .lag(lag), .tx_done(tx_done), .tx_abort(tx_abort));

    // Clock and the record of started mailboxes and dropped frames
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (tx_start === 1'b1) begin
            prev_mbx <= seen_mbx;
            seen_mbx <= tx_mbx;
        end
        if (rx_dropped === 1'b1) drops <= drops + 1;
        if (rx_store === 1'b1) stores <= stores + 1;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One single AHB transfer; fire pulses rx_valid at the data-phase end
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic fire);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        rx_valid <= fire;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        if (fire) rx_valid <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b0);
    endtask : wr

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 1'b0);
        chk("hresp", hresp, 32'h0000_0000);
        chk(name, rd, exp);
    endtask : rchk

    // Poll the request word until every queued mailbox has gone
    task automatic wait_idle();
        for (int i = 0; i < 40; i++) begin
            bus(1'b0, cmf_pkg::OFF_TX_REQUEST_SET, 32'h0000_0000, 1'b0);
            if (rd === 32'h0000_0000) return;
        end
        chk("tx queue drained", rd, 32'h0000_0000);
    endtask : wait_idle

    task automatic rx(input logic [31:0] m);
        rx_match <= m;
        rx_valid <= 1'b1;
        @(posedge hclk);
        rx_valid <= 1'b0;
        @(posedge hclk);
        @(posedge hclk);
    endtask : rx

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        complete_run();
    end

    initial begin
        {hsel, hwrite, rx_valid, fail_next, htrans, haddr, hwdata, rx_match} = '0;
        {fail_count, checked, drops, stores, seen_mbx, prev_mbx} = '0;
        hsize = 3'b010;
        lag = 4'h2;
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values of the six mailbox flag words (global flag word not read) and an unmapped word
        for (int a = 0; a < 24; a += 4) rchk("flag reset", a[7:0], 32'h0000_0000);
        rchk("unmapped", 8'h3C, 32'h0000_0000);
        $display("test reset done");
        // Two queued mailboxes, success flags and their clearing
        wr(cmf_pkg::OFF_MAILBOX_IRQ_MASK, 32'h0000_020C);
        wr(cmf_pkg::OFF_MAILBOX_IRQ_LEVEL, 32'h0000_0004);
        wr(cmf_pkg::OFF_GLOBAL_IRQ_MASK, 32'h0000_4800);
        wr(cmf_pkg::OFF_TX_REQUEST_SET, 32'h0000_0208);
        wait_idle();
        chk("first sent", prev_mbx, 32'h0000_0009);
        chk("second sent", seen_mbx, 32'h0000_0003);
        rchk("success", cmf_pkg::OFF_TX_SUCCESS_ACK, 32'h0000_0208);
        rchk("global", cmf_pkg::OFF_GLOBAL_IRQ_FLAG, 32'h0000_8000);
        chk("line0", irq_line0, 32'h0000_0001);
        wr(cmf_pkg::OFF_TX_SUCCESS_ACK, 32'h0000_0000);
        rchk("success zero", cmf_pkg::OFF_TX_SUCCESS_ACK, 32'h0000_0208);
        wr(cmf_pkg::OFF_TX_SUCCESS_ACK, 32'h0000_0008);
        rchk("success one", cmf_pkg::OFF_TX_SUCCESS_ACK, 32'h0000_0200);
        wr(cmf_pkg::OFF_TX_SUCCESS_ACK, 32'h0000_0200);
        rchk("success none", cmf_pkg::OFF_TX_SUCCESS_ACK, 32'h0000_0000);
        chk("line0 off", irq_line0, 32'h0000_0000);
        $display("test success done");
        // Aborted transmission
        fail_next <= 1'b1;
        wr(cmf_pkg::OFF_TX_REQUEST_SET, 32'h0000_0080);
        wait_idle();
        rchk("abort", cmf_pkg::OFF_TX_ABORT_ACK, 32'h0000_0080);
        rchk("global abort", cmf_pkg::OFF_GLOBAL_IRQ_FLAG, 32'h0000_4000);
        chk("line0 abort", irq_line0, 32'h0000_0001);
        wr(cmf_pkg::OFF_TX_ABORT_ACK, 32'h0000_0080);
        rchk("abort clear", cmf_pkg::OFF_TX_ABORT_ACK, 32'h0000_0000);
        fail_next <= 1'b0;
        $display("test abort done");
        // Cancel of a queued and of the in-flight mailbox
        lag <= 4'hF;
        wr(cmf_pkg::OFF_TX_REQUEST_SET, 32'h0010_0010);
        while (tx_start !== 1'b1) @(posedge hclk);
        wr(cmf_pkg::OFF_TX_REQUEST_CANCEL, 32'h0010_0010);
        @(posedge hclk);
        rchk("request left", cmf_pkg::OFF_TX_REQUEST_SET, 32'h0010_0000);
        rchk("cancel held", cmf_pkg::OFF_TX_REQUEST_CANCEL, 32'h0010_0000);
        wait_idle();
        rchk("cancel cleared", cmf_pkg::OFF_TX_REQUEST_CANCEL, 32'h0000_0000);
        rchk("active sent", cmf_pkg::OFF_TX_SUCCESS_ACK, 32'h0010_0000);
        rchk("withdrawn", cmf_pkg::OFF_TX_ABORT_ACK, 32'h0000_0010);
        wr(cmf_pkg::OFF_TX_SUCCESS_ACK, 32'h0010_0000);
        wr(cmf_pkg::OFF_TX_ABORT_ACK, 32'h0000_0010);
        $display("test cancel done");
        // Reception, overwrite, loss and protection
        wr(cmf_pkg::OFF_OVERWRITE_PROTECT, 32'h0000_0040);
        rx(32'h0000_0004);
        chk("store mbx", rx_store_mbx, 32'h0000_0002);
        rchk("pending", cmf_pkg::OFF_RX_MESSAGE_PENDING, 32'h0000_0004);
        chk("line1", irq_line1, 32'h0000_0001);
        rx(32'h0000_0004);
        rchk("lost", cmf_pkg::OFF_RX_MESSAGE_LOST, 32'h0000_0004);
        rchk("global lost", cmf_pkg::OFF_GLOBAL_IRQ_FLAG, 32'h0000_8800);
        chk("line0 lost", irq_line0, 32'h0000_0001);
        wr(cmf_pkg::OFF_RX_MESSAGE_LOST, 32'hFFFF_FFFF);
        rchk("lost ro", cmf_pkg::OFF_RX_MESSAGE_LOST, 32'h0000_0004);
        wr(cmf_pkg::OFF_RX_MESSAGE_PENDING, 32'h0000_0004);
        rchk("lost clr", cmf_pkg::OFF_RX_MESSAGE_LOST, 32'h0000_0000);
        rchk("pend clr", cmf_pkg::OFF_RX_MESSAGE_PENDING, 32'h0000_0000);
        rx(32'h0000_0042);
        chk("protect first", rx_store_mbx, 32'h0000_0006);
        rx(32'h0000_0042);
        chk("protect next", rx_store_mbx, 32'h0000_0001);
        rx(32'h0000_0040);
        chk("dropped", drops, 32'h0000_0001);
        rchk("no loss", cmf_pkg::OFF_RX_MESSAGE_LOST, 32'h0000_0000);
        rx_match <= 32'h0000_0001;
        bus(1'b1, cmf_pkg::OFF_RX_MESSAGE_PENDING, 32'h0000_0001, 1'b1);
        rchk("set wins", cmf_pkg::OFF_RX_MESSAGE_PENDING, 32'h0000_0043);
        chk("stores", stores, 32'h0000_0005);
        $display("test receive done");
        complete_run();
    end
endmodule : cmf_mailbox_flags_tb_top
